/* File: rtl/adcpc_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// Conversion, power-down and status control of the converter
module adcpc_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        sclk,
  input  wire logic        frame_select,
  input  wire logic        serial_data_in,
  output logic             serial_data_out,
  input  wire logic        convert_start_pin,
  input  wire logic [15:0] core_result,
  output logic             status_pin,
  output logic             core_nap,
  output logic             core_deep,
  output logic             conv_start,
  output logic [2:0]       channel_select,
  output logic [11:0]      config_word
);
  // Command compare, used for several decodes
  function automatic logic is_cmd(input logic [3:0] nib,
                                  input logic [3:0] code);
    is_cmd = (nib == code);
  endfunction

  // Link side results
  logic        nib_tgl;   // Toggles at fourth falling edge
  logic [3:0]  nib_val;   // Command nibble, stable between toggles
  logic        wrd_tgl;   // Toggles at sixteenth falling edge
  logic [15:0] wrd_val;   // Whole input word
  logic [15:0] tx_word;   // Word shifted out, changed only when idle

  adcpc_serial u_serial (
    .sclk            (sclk),
    .rst             (rst),
    .frame_select    (frame_select),
    .serial_data_in  (serial_data_in),
    .tx_word         (tx_word),
    .serial_data_out (serial_data_out),
    .nib_tgl         (nib_tgl),
    .nib_val         (nib_val),
    .wrd_tgl         (wrd_tgl),
    .wrd_val         (wrd_val)
  );

  // Conversion clock tick from the internal oscillator divider
  logic [1:0] div;   // Divider phase
  logic       tick;  // One system cycle per conversion clock
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div  <= 2'h0;
      tick <= 1'b0;
    end else if (div == adcpc_pkg::CONVERSION_CLOCK_DIV - 2'h1) begin
      div  <= 2'h0;
      tick <= 1'b1;
    end else begin
      div  <= div + 2'h1;
      tick <= 1'b0;
    end
  end

  // Synchronisers; stage 0 feeds stage 1 only
  logic [2:0] cs_sync;   // Convert start pin
  logic [2:0] fr_sync;   // Frame select level
  logic [2:0] nib_sync;  // Nibble toggle
  logic [2:0] wrd_sync;  // Word toggle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cs_sync  <= 3'h7;
      fr_sync  <= 3'h7;
      nib_sync <= 3'h0;
      wrd_sync <= 3'h0;
    end else begin
      cs_sync  <= {cs_sync[1:0], convert_start_pin};
      fr_sync  <= {fr_sync[1:0], frame_select};
      nib_sync <= {nib_sync[1:0], nib_tgl};
      wrd_sync <= {wrd_sync[1:0], wrd_tgl};
    end
  end

  logic cs_fall;     // Convert start falling edge
  logic fr_fall;     // Start of a serial cycle
  logic fr_idle;     // No frame in progress
  logic cmd_evt;     // A command nibble has arrived
  logic wr_evt;      // A full word has arrived
  assign cs_fall = cs_sync[2] & ~cs_sync[1];
  assign fr_fall = fr_sync[2] & ~fr_sync[1];
  assign fr_idle = fr_sync[1];
  assign cmd_evt = nib_sync[2] ^ nib_sync[1];
  assign wr_evt  = wrd_sync[2] ^ wrd_sync[1];

  // Command decode
  logic is_wake;  // Wake command
  logic is_dflt;  // Default load, also the software reset
  logic is_chan;  // Manual channel select
  logic is_wr;    // Configuration write
  logic is_rdcfg; // Configuration read-back request
  assign is_wake  = cmd_evt & is_cmd(nib_val, adcpc_pkg::CMD_WAKE);
  assign is_chan  = cmd_evt & ~nib_val[3];
  assign is_rdcfg = cmd_evt & is_cmd(nib_val, adcpc_pkg::CMD_RDCFG);
  assign is_wr    = wr_evt & is_cmd(wrd_val[15:12], adcpc_pkg::CMD_WRITE);
  assign is_dflt  = (cmd_evt & is_cmd(nib_val, adcpc_pkg::CMD_DFLT))
                  | (is_wr & ~wrd_val[adcpc_pkg::BIT_SRST]);

  // Configuration word; a wake command drops the manual power-downs
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      config_word <= adcpc_pkg::CFG_RESET;
    end else if (is_dflt) begin
      config_word <= adcpc_pkg::CFG_RESET;
    end else if (is_wr) begin
      config_word <= wrd_val[11:0];
    end else if (is_wake) begin
      config_word[adcpc_pkg::BIT_DEEP] <= 1'b0;
      config_word[adcpc_pkg::BIT_NAP]  <= 1'b0;
    end
  end

  // Selected input channel
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      channel_select <= 3'h0;
    end else if (is_chan) begin
      channel_select <= nib_val[2:0];
    end
  end

  // Decoded configuration fields
  logic       cfg_deep;   // Deep power-down requested
  logic       cfg_nap;    // Nap power-down requested
  logic       cfg_anap;   // Automatic nap enabled
  logic       cfg_man;    // Manual trigger
  logic       cfg_slow;   // Slow automatic rate
  logic [1:0] cfg_fn;     // Status function field
  logic       pol_low;    // Status asserted low
  assign cfg_deep = config_word[adcpc_pkg::BIT_DEEP];
  assign cfg_nap  = config_word[adcpc_pkg::BIT_NAP];
  assign cfg_anap = config_word[adcpc_pkg::BIT_ANAP];
  assign cfg_man  = config_word[adcpc_pkg::BIT_TRIG];
  assign cfg_slow = config_word[adcpc_pkg::BIT_RATE];
  assign cfg_fn   = config_word[adcpc_pkg::BIT_POL:adcpc_pkg::FN_LO];
  assign pol_low  = config_word[adcpc_pkg::BIT_POL];

  // Automatic nap allowed in manual trigger or at the slow rate
  logic anap_ok;
  assign anap_ok = cfg_anap & (cfg_man | cfg_slow);

  // Sequencer state and conversion clock counter
  adcpc_pkg::adcpc_state_t state;
  logic [4:0]   cnt;
  logic         eoc;        // One-cycle end of conversion
  logic         auto_sleep; // Core napped by automatic nap
  logic         nap_pend;   // Nap due one clock after conversion
  logic [5:0]   wake_cnt;   // System cycles left of a wake-up
  logic         ready;      // Core powered and settled
  logic         pd_req;     // Manual nap or deep requested
  logic         anap_wake;  // Command or disable ends automatic nap
  logic         man_wake;   // Convert start ends automatic nap
  logic         gap_wake;   // Slow rate wake ahead of a start

  assign pd_req    = cfg_deep | cfg_nap;
  assign ready     = ~pd_req & (wake_cnt == 6'h00);
  assign anap_wake = auto_sleep
                   & (is_wake | is_dflt | is_chan | ~cfg_anap);
  assign man_wake  = (state == adcpc_pkg::ST_IDLE) & cfg_man & cs_fall
                   & ready & auto_sleep;
  assign gap_wake  = (state == adcpc_pkg::ST_GAP) & tick & auto_sleep
                   & (cnt == adcpc_pkg::ANAP_RISE);

  // Wake-up timer; held loaded while a power-down is asked for
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wake_cnt <= 6'h00;
    end else if (pd_req) begin
      wake_cnt <= cfg_deep ? 6'(adcpc_pkg::DEEP_WAKE_CYC)
                           : 6'(adcpc_pkg::NAP_WAKE_CYC);
    end else if (anap_wake) begin
      wake_cnt <= 6'(adcpc_pkg::NAP_WAKE_CYC);
    end else if (wake_cnt != 6'h00) begin
      wake_cnt <= wake_cnt - 6'h01;
    end
  end

  // Automatic nap; waking beats a nap that falls due together
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      auto_sleep <= 1'b0;
      nap_pend   <= 1'b0;
    end else if (anap_wake | man_wake | gap_wake | ~anap_ok) begin
      auto_sleep <= 1'b0;
      nap_pend   <= 1'b0;
    end else if (eoc) begin
      nap_pend   <= 1'b1;
    end else if (nap_pend & tick) begin
      auto_sleep <= 1'b1;
      nap_pend   <= 1'b0;
    end
  end

  // Conversion sequencer, stepped on conversion clock ticks
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state      <= adcpc_pkg::ST_IDLE;
      cnt        <= 5'h00;
      conv_start <= 1'b0;
      eoc        <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      eoc        <= 1'b0;
      case (state)
        adcpc_pkg::ST_IDLE: begin
          if (cfg_man) begin
            // Starts before the core has woken are dropped
            if (cs_fall & ready & auto_sleep) begin
              state <= adcpc_pkg::ST_ACQ;
              cnt   <= adcpc_pkg::ANAP_START;
            end else if (cs_fall & ready) begin
              state      <= adcpc_pkg::ST_CONV;
              cnt        <= adcpc_pkg::CONV_CONVERSION_CLOCK;
              conv_start <= 1'b1;
            end
          end else if (ready) begin
            state <= adcpc_pkg::ST_GAP;
            cnt   <= adcpc_pkg::ACQ_CONVERSION_CLOCK;
          end
        end
        adcpc_pkg::ST_GAP: begin
          // Acquisition, and at the slow rate the idle spacing too
          if (!ready | cfg_man) begin
            state <= adcpc_pkg::ST_IDLE;
          end else if (tick & (cnt == 5'h01)) begin
            state      <= adcpc_pkg::ST_CONV;
            cnt        <= adcpc_pkg::CONV_CONVERSION_CLOCK;
            conv_start <= 1'b1;
          end else if (tick) begin
            cnt <= cnt - 5'h01;
          end
        end
        adcpc_pkg::ST_ACQ: begin
          // Three clocks wake plus three clocks acquisition
          if (tick & (cnt == 5'h01)) begin
            state      <= adcpc_pkg::ST_CONV;
            cnt        <= adcpc_pkg::CONV_CONVERSION_CLOCK;
            conv_start <= 1'b1;
          end else if (tick) begin
            cnt <= cnt - 5'h01;
          end
        end
        adcpc_pkg::ST_CONV: begin
          if (tick & (cnt == 5'h01)) begin
            eoc <= 1'b1;
            if (cfg_man) begin
              state <= adcpc_pkg::ST_IDLE;
            end else begin
              state <= adcpc_pkg::ST_GAP;
              cnt   <= cfg_slow ? adcpc_pkg::GAP_SLOW
                                : adcpc_pkg::GAP_FAST;
            end
          end else if (tick) begin
            cnt <= cnt - 5'h01;
          end
        end
        default: begin
          state <= adcpc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Result latched at end of conversion
  logic [15:0] result;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      result <= 16'h0000;
    end else if (eoc) begin
      result <= core_result;
    end
  end

  // Read-back request; a new request beats the clear of a frame
  logic rdcfg;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdcfg <= 1'b0;
    end else if (is_rdcfg) begin
      rdcfg <= 1'b1;
    end else if (fr_fall) begin
      rdcfg <= 1'b0;
    end
  end

  // Output word changes only between frames so the link reads it whole
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_word <= 16'h0000;
    end else if (fr_idle) begin
      tx_word <= rdcfg ? {result[15:12], config_word} : result;
    end
  end

  // Interrupt flag; a conversion ending beats a read clearing it
  logic int_flag;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      int_flag <= 1'b0;
    end else if (eoc) begin
      int_flag <= 1'b1;
    end else if (fr_fall) begin
      int_flag <= 1'b0;
    end
  end

  // Status pin: function select, then polarity
  logic stat_on;
  always_comb begin
    stat_on = 1'b0;
    if (cfg_fn == adcpc_pkg::FN_EOC) begin
      stat_on = (state == adcpc_pkg::ST_CONV);
    end else if (cfg_fn == adcpc_pkg::FN_INT) begin
      stat_on = int_flag;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status_pin <= 1'b1;
      core_nap   <= 1'b0;
      core_deep  <= 1'b0;
    end else begin
      status_pin <= (stat_on & ready) ^ pol_low;
      core_nap   <= cfg_nap | auto_sleep;
      core_deep  <= cfg_deep;
    end
  end

  // Helper: system cycles spent converting
  logic [6:0] conv_len;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      conv_len <= 7'h00;
    end else if (conv_start) begin
      conv_len <= 7'h01;
    end else if (state == adcpc_pkg::ST_CONV) begin
      conv_len <= conv_len + 7'h01;
    end
  end

  sequence s_conv_done;
    ##[1:3] (state != adcpc_pkg::ST_CONV);
  endsequence

  property p_conv_len;
    @(posedge sys_clk) disable iff (rst)
      $rose(eoc) |-> conv_len >= 7'h34 && conv_len <= 7'h37;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion length is not 18 clocks");

  property p_eoc_pin;
    @(posedge sys_clk) disable iff (rst)
      (cfg_fn == 2'h3) && ready && conv_start && $stable(config_word)
        |=> ##1 (status_pin == ~pol_low);
  endproperty
  a_eoc_pin: assert property (p_eoc_pin)
    else $error("status not asserted during conversion");

  property p_int_set;
    @(posedge sys_clk) disable iff (rst)
      eoc && (cfg_fn == 2'h2) && ready && $stable(config_word)
        |=> int_flag ##1 (status_pin == ~pol_low);
  endproperty
  a_int_set: assert property (p_int_set)
    else $error("interrupt not raised at end of conversion");

  property p_int_clr;
    @(posedge sys_clk) disable iff (rst)
      fr_fall && !eoc |=> !int_flag;
  endproperty
  a_int_clr: assert property (p_int_clr)
    else $error("interrupt not cleared by read cycle");

  property p_anap_enter;
    @(posedge sys_clk) disable iff (rst)
      eoc && anap_ok && !anap_wake && $stable(config_word)
        && !cs_fall |-> ##[1:4] auto_sleep;
  endproperty
  a_anap_enter: assert property (p_anap_enter)
    else $error("automatic nap not entered one clock after conversion");

  property p_man_wake;
    @(posedge sys_clk) disable iff (rst)
      man_wake |=> !conv_start [*8] ##[9:12] conv_start;
  endproperty
  a_man_wake: assert property (p_man_wake)
    else $error("manual start after nap not six clocks later");

  property p_deep_wake;
    @(posedge sys_clk) disable iff (rst)
      $fell(cfg_deep) && !cfg_nap |-> ##39 !ready ##1 ready;
  endproperty
  a_deep_wake: assert property (p_deep_wake)
    else $error("deep wake-up not 1 us");

  property p_fast_awake;
    @(posedge sys_clk) disable iff (rst)
      !cfg_man && !cfg_slow |=> !auto_sleep;
  endproperty
  a_fast_awake: assert property (p_fast_awake)
    else $error("core napped at fast automatic rate");

  property p_conv_end;
    @(posedge sys_clk) disable iff (rst)
      eoc |-> s_conv_done or (state == adcpc_pkg::ST_IDLE);
  endproperty
  a_conv_end: assert property (p_conv_end)
    else $error("sequencer stayed in conversion after its end");
endmodule
`default_nettype wire

/* File: rtl/adcpc_pkg.sv */
package adcpc_pkg;
  // System clock period and deep wake time
  localparam int SYS_PERIOD_NS = 25;
  localparam int DEEP_WAKE_NS  = 1000;
  localparam int DEEP_WAKE_CYC =
    (DEEP_WAKE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  // Internal oscillator: one conversion clock per three system cycles
  localparam logic [1:0] CONVERSION_CLOCK_DIV = 2'h3;
  // Counts in conversion clocks
  localparam logic [4:0] ACQ_CONVERSION_CLOCK   = 5'h03;
  localparam logic [4:0] CONV_CONVERSION_CLOCK  = 5'h12;
  localparam logic [4:0] ANAP_START = 5'h06;
  localparam logic [4:0] GAP_FAST   = 5'h03;
  localparam logic [4:0] GAP_SLOW   = 5'h18;
  // Gap count at which the core wakes: six ticks remain to the start
  localparam logic [4:0] ANAP_RISE  = 5'h07;
  localparam int NAP_WAKE_CYC = 3 * CONVERSION_CLOCK_DIV;
  // Configuration word field positions
  localparam int BIT_SRST = 0;
  localparam int BIT_DEEP = 2;
  localparam int BIT_NAP  = 3;
  localparam int BIT_ANAP = 4;
  localparam int BIT_POL  = 7;
  localparam int FN_LO    = 6;
  localparam int BIT_RATE = 8;
  localparam int BIT_TRIG = 9;
  // Value after reset or default load
  localparam logic [11:0] CFG_RESET = 12'hFE3;
  // Status function codes
  localparam logic [1:0] FN_EOC = 2'h3;
  localparam logic [1:0] FN_INT = 2'h2;
  // Command nibbles
  localparam logic [3:0] CMD_WAKE  = 4'hB;
  localparam logic [3:0] CMD_RDCFG = 4'hC;
  localparam logic [3:0] CMD_WRITE = 4'hE;
  localparam logic [3:0] CMD_DFLT  = 4'hF;
  // Serial frame positions, in falling edges counted from zero
  localparam logic [4:0] NIB_LAST  = 5'h03;
  localparam logic [4:0] WORD_LAST = 5'h0F;
  localparam logic [4:0] FRAME_END = 5'h10;
  // Conversion sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_GAP  = 4'h2,
    ST_ACQ  = 4'h4,
    ST_CONV = 4'h8
  } adcpc_state_t;
endpackage

/* File: rtl/adcpc_serial.sv */
`timescale 1ns/1ps
`default_nettype none
// Link-side shifter, clocked by the host serial clock
module adcpc_serial (
  input  wire logic        sclk,
  input  wire logic        rst,
  input  wire logic        frame_select,
  input  wire logic        serial_data_in,
  input  wire logic [15:0] tx_word,
  output logic             serial_data_out,
  output logic             nib_tgl,
  output logic [3:0]       nib_val,
  output logic             wrd_tgl,
  output logic [15:0]      wrd_val
);
  logic [4:0]  bitn;   // Falling edges seen in this frame
  logic [15:0] shift;  // Input bits, newest in bit 0

  // Frame high clears the count; sclk may idle high at the fall
  always_ff @(negedge sclk or posedge frame_select) begin
    if (frame_select) begin
      bitn  <= 5'h00;
      shift <= 16'h0000;
    end else if (bitn != adcpc_pkg::FRAME_END) begin
      bitn  <= bitn + 5'h01;
      shift <= {shift[14:0], serial_data_in};
    end
  end

  // Toggles carry the nibble and word events to the system side
  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      nib_tgl <= 1'b0;
      nib_val <= 4'h0;
      wrd_tgl <= 1'b0;
      wrd_val <= 16'h0000;
    end else if (!frame_select) begin
      if (bitn == adcpc_pkg::NIB_LAST) begin
        nib_val <= {shift[2:0], serial_data_in};
        nib_tgl <= ~nib_tgl;
      end
      if (bitn == adcpc_pkg::WORD_LAST) begin
        wrd_val <= {shift[14:0], serial_data_in};
        wrd_tgl <= ~wrd_tgl;
      end
    end
  end

  // MSB shows as soon as the frame falls; next bit after each fall
  assign serial_data_out = bitn[4] ? 1'b0 : tx_word[~bitn[3:0]];

  property p_word_edge;
    @(negedge sclk) disable iff (rst)
      $changed(wrd_tgl) |-> $past(bitn) == 5'h0F;
  endproperty
  a_word_edge: assert property (p_word_edge)
    else $error("word event not at sixteenth falling edge");
endmodule
`default_nettype wire

/* File: tb/adcpc_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the converter control block
module adcpc_ctrl_tb;
  logic        sys_clk = 1'b0;   // 40 MHz system clock
  logic        rst = 1'b1;       // Async reset
  logic        sclk;             // From host model
  logic        frame_select;     // From host model
  logic        serial_data_in;   // From host model
  logic        serial_data_out;  // To host model
  logic        convert_start_pin = 1'b1;
  logic [15:0] core_result = 16'hA5C3;
  logic        status_pin;
  logic        core_nap;
  logic        core_deep;
  logic        conv_start;
  logic [2:0]  channel_select;
  logic [11:0] config_word;
  logic [15:0] rx;               // Word seen by the host
  int          bad_count = 0;
  int          compares = 0;
  int          cycles = 0;
  int          n;
  int          m;

  adcpc_ctrl adcpc_ctrl_inst (.sys_clk(sys_clk), .rst(rst), .sclk(sclk),
    .frame_select(frame_select), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out), .convert_start_pin(convert_start_pin),
    .core_result(core_result), .status_pin(status_pin), .core_nap(core_nap),
    .core_deep(core_deep), .conv_start(conv_start),
    .channel_select(channel_select), .config_word(config_word));

  adcpc_host adcpc_host_inst (.sclk(sclk), .frame_select(frame_select),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out));

  // Clock: half period 12.5 ns
  always #12.5 sys_clk = ~sys_clk;

  // Hang guard, well above the few thousand cycles the tests need
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      bad_count = bad_count + 1;
      conclude();
    end
  end

  // Verdict, printed in one place
  task automatic conclude();
    $display("checks %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Compare of a design value
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    compares = compares + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Compare of a measured cycle count against a window
  task automatic chk_len(input string what, input int lo, input int hi,
                         input int got);
    compares = compares + 1;
    if (got < lo || got > hi) begin
      bad_count = bad_count + 1;
      $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  // Step k cycles and sample after the last edge has settled
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  // Convert-start pin low for two cycles; returns early so that a
  // start three cycles after the fall is still seen by wait_start
  task automatic pulse_pin();
    @(posedge sys_clk);
    convert_start_pin <= 1'b0;
    @(posedge sys_clk);
    @(posedge sys_clk);
    convert_start_pin <= 1'b1;
  endtask

  // Cycles until the next internal start, bounded
  task automatic wait_start(output int k);
    k = 0;
    while (conv_start !== 1'b1 && k < 400) begin
      tick(1);
      k++;
    end
    chk("conv_start", 16'h1, {15'h0, conv_start});
    tick(1);
  endtask

  // Cycles the status pin stays at one level, bounded
  task automatic hold_len(input logic lvl, output int k);
    k = 0;
    while (status_pin === lvl && k < 300) begin
      tick(1);
      k++;
    end
  endtask

  // Full write of the configuration word
  task automatic cfg(input logic [11:0] v);
    adcpc_host_inst.xfer({4'hE, v}, rx);
    tick(8);
    chk("config_word", {4'h0, v}, {4'h0, config_word});
  endtask

  // Command nibble with don't-care data
  task automatic cmd(input logic [3:0] c);
    adcpc_host_inst.xfer({c, 12'h000}, rx);
    tick(8);
  endtask

  initial begin
    tick(6);
    rst <= 1'b0;
    tick(2);
    chk("status_pin", 16'h1, {15'h0, status_pin});
    chk("config_word", 16'h0FE3, {4'h0, config_word});
    chk("core_nap", 16'h0, {15'h0, core_nap});
    chk("core_deep", 16'h0, {15'h0, core_deep});
    $display("test reset done");
    // Manual start, active-low end-of-conversion
    pulse_pin();
    wait_start(n);
    chk("status_pin", 16'h0, {15'h0, status_pin});
    hold_len(1'b0, n);
    chk_len("eoc_low_cycles", 51, 56, n);
    cmd(4'hD);
    chk("result_word", 16'hA5C3, rx);
    cmd(4'hC);
    cmd(4'hD);
    chk("readback_word", 16'hAFE3, rx);
    $display("test manual done");
    // Interrupt mode: set at end of conversion, cleared by a frame
    cfg(12'hFA3);
    pulse_pin();
    wait_start(n);
    tick(70);
    chk("status_pin", 16'h0, {15'h0, status_pin});
    cmd(4'hD);
    chk("status_pin", 16'h1, {15'h0, status_pin});
    $display("test interrupt done");
    // Nap and deep entry and wake
    cfg(12'hFEB);
    chk("core_nap", 16'h1, {15'h0, core_nap});
    cmd(4'hB);
    chk("core_nap", 16'h0, {15'h0, core_nap});
    chk("config_word", 16'h0FE3, {4'h0, config_word});
    cfg(12'hFE7);
    chk("core_deep", 16'h1, {15'h0, core_deep});
    cfg(12'hFE3);
    chk("core_deep", 16'h0, {15'h0, core_deep});
    tick(50);
    $display("test powerdown done");
    // Automatic nap under manual trigger
    cfg(12'hFF3);
    pulse_pin();
    wait_start(n);
    hold_len(1'b0, n);
    tick(5);
    chk("core_nap", 16'h1, {15'h0, core_nap});
    pulse_pin();
    wait_start(n);
    chk_len("wake_to_start", 13, 22, n);
    hold_len(1'b0, n);
    tick(6);
    cmd(4'h3);
    chk("core_nap", 16'h0, {15'h0, core_nap});
    chk("channel_select", 16'h3, {13'h0, channel_select});
    $display("test autonap done");
    // Automatic trigger, fast rate keeps the core awake
    cfg(12'hCF3);
    wait_start(n);
    wait_start(n);
    chk_len("fast_spacing", 62, 62, n);
    hold_len(1'b0, n);
    hold_len(1'b1, m);
    chk_len("eoc_idle", 9, 11, m);
    chk("core_nap", 16'h0, {15'h0, core_nap});
    // Slow rate with automatic nap
    cfg(12'hDF3);
    wait_start(n);
    wait_start(n);
    chk_len("slow_spacing", 125, 125, n);
    hold_len(1'b0, n);
    tick(6);
    chk("core_nap", 16'h1, {15'h0, core_nap});
    // Default load returns to manual trigger and wakes the core
    cmd(4'hF);
    chk("config_word", 16'h0FE3, {4'h0, config_word});
    tick(12);
    chk("core_nap", 16'h0, {15'h0, core_nap});
    $display("test auto done");
    conclude();
  end
endmodule
`default_nettype wire

/* File: tb/adcpc_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Host model: drives frames with a 160 ns serial clock, idle high
module adcpc_host (
  output logic      sclk,
  output logic      frame_select,
  output logic      serial_data_in,
  input  wire logic serial_data_out
);
  // Idle: frame high, clock parked high
  initial begin
    sclk = 1'b1;
    frame_select = 1'b1;
    serial_data_in = 1'b0;
  end
  // One 16-bit frame, MSB first; clock stands still outside the frame
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    frame_select = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      serial_data_in = tx[i];
      #79 rx[i] = serial_data_out;
      #1 sclk = 1'b0;
      #80 sclk = 1'b1;
    end
    #80 frame_select = 1'b1;
    // Released data line shows the inverse so a stale bit never matches
    serial_data_in = ~tx[0];
    #200;
  endtask
endmodule
`default_nettype wire
